// ---- core/capsense_pkg.sv ----
// Shared constants, types and register map of the front-end control block
package capsense_pkg;

	// ------------------------------------------------------------------
	// Command codes: read code, write code is read code plus 0x10
	// ------------------------------------------------------------------
	localparam logic [7:0] WR_FLAG_MASK     = 8'h10;
	localparam logic [7:0] OFS_SHIELD_ATTEN = 8'h24;
	localparam logic [7:0] OFS_TIA_GAIN     = 8'h25;
	localparam logic [7:0] OFS_DEMOD_ROUTE  = 8'h26;
	localparam logic [7:0] OFS_AMP_GAIN     = 8'h27;
	localparam logic [7:0] OFS_I_OFFSET     = 8'h28;
	localparam logic [7:0] OFS_Q_OFFSET     = 8'h29;
	localparam logic [7:0] OFS_CONV_CTL     = 8'h2a;
	localparam logic [7:0] OFS_BLANKING     = 8'h2b;
	localparam logic [7:0] OFS_PROBE_SEL    = 8'h2c;
	localparam logic [7:0] OFS_ADC_STATUS   = 8'h05;
	localparam logic [7:0] CMD_DATA_READ    = 8'h90;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [1:0] RST_TWO_BIT  = 2'h0;
	localparam logic [2:0] RST_AMP_GAIN = 3'h0;
	localparam logic [7:0] RST_OFFSET   = 8'h00;
	localparam logic [7:0] RST_CONV_CTL = 8'h00;
	localparam logic [5:0] RST_BLANKING = 6'h3f;
	localparam logic [7:0] RST_PROBE    = 8'hff;

	// ------------------------------------------------------------------
	// Conversion control fields and timing counts
	// ------------------------------------------------------------------
	localparam int SETTLE_POS = 6;
	localparam int ACCUM_POS  = 4;
	localparam int DIV_POS    = 2;
	localparam int MODE_POS   = 0;
	localparam logic [11:0] SETTLE_CYC_00 = 12'd1600;
	localparam logic [11:0] SETTLE_CYC_01 = 12'd2304;
	localparam logic [11:0] SETTLE_CYC_10 = 12'd2656;
	localparam logic [4:0]  DIV_BY_16 = 5'd16;
	localparam logic [4:0]  DIV_BY_8  = 5'd8;
	localparam logic [4:0]  DIV_BY_4  = 5'd4;
	localparam logic [4:0]  CONV_TICKS_PER_SAMPLE = 5'd22;
	localparam logic [4:0]  SAMPLES_4  = 5'd4;
	localparam logic [4:0]  SAMPLES_8  = 5'd8;
	localparam logic [4:0]  SAMPLES_16 = 5'd16;
	localparam logic [14:0] OFFSET_STEP = 15'd80;
	localparam logic [3:0]  PROBE_SHIELD_CODE = 4'hb;
	localparam logic [3:0]  PROBE_LAST_LINE   = 4'h9;
	localparam int DIAG_N = 4;

	typedef enum logic [1:0] {
		MODE_RESET  = 2'h0,
		MODE_SINGLE = 2'h1,
		MODE_REPEAT = 2'h2,
		MODE_STOP   = 2'h3
	} conv_mode_type;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_SETTLE = 4'h2,
		ST_SAMPLE = 4'h4,
		ST_HOLD   = 4'h8
	} conv_state_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] wdata;
	} cmd_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} rsp_type;

endpackage

// ---- core/conv_divider.sv ----
// Converter clock divider with a one-cycle tick per converter period
`timescale 1ns/1ps
module conv_divider import capsense_pkg::*; (
	input  wire logic       clk,      // Core clock
	input  wire logic       nrst,     // Async reset, active low
	input  wire logic       run,      // Divider runs while high
	input  wire logic [1:0] div_sel,  // Divider select code
	output logic            conv_clk, // Divided converter clock
	output logic            tick      // Pulse at end of each period
);
	logic [4:0] cnt_q;
	logic [4:0] period;

	always_comb begin
		unique case (div_sel)
			2'h1:    period = DIV_BY_8;
			2'h2:    period = DIV_BY_4;
			default: period = DIV_BY_16;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 5'd0;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= 5'd0;
			tick  <= 1'b0;
		end else begin
			tick  <= (cnt_q == period - 5'd1);
			cnt_q <= (cnt_q == period - 5'd1) ? 5'd0 : cnt_q + 5'd1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			conv_clk <= 1'b0;
		end else begin
			conv_clk <= run && (cnt_q < (period >> 1));
		end
	end
endmodule // conv_divider

// ---- core/blank_filter.sv ----
// Up/down blanking counter for one diagnostic input
`timescale 1ns/1ps
module blank_filter (
	input  wire logic       clk,      // Core clock
	input  wire logic       nrst,     // Async reset, active low
	input  wire logic       fault,    // Synchronised raw diagnostic
	input  wire logic [5:0] terminal, // Programmed terminal count
	output logic            report    // Filtered fault indication
);
	logic [5:0] cnt_q;

	// Counts up while the fault is present, down while absent
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 6'd0;
		end else if (fault && cnt_q != 6'h3f) begin
			cnt_q <= cnt_q + 6'd1;
		end else if (!fault && cnt_q != 6'd0) begin
			cnt_q <= cnt_q - 6'd1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			report <= 1'b0;
		end else begin
			report <= (cnt_q >= terminal) && (cnt_q != 6'd0);
		end
	end
endmodule // blank_filter

// ---- core/capsense_frontend_config_adc_ctl.sv ----
// Front-end settings registers and conversion sequencer
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module capsense_frontend_config_adc_ctl import capsense_pkg::*; (
	input  wire logic              clk,               // Core clock
	input  wire logic              nrst,              // Async reset
	input  wire cmd_type           cmd,               // Serial command
	input  wire logic [9:0]        adc_i_pin,         // I sample pins
	input  wire logic [9:0]        adc_q_pin,         // Q sample pins
	input  wire logic              inphase_clock,     // I demod clock
	input  wire logic              quadrature_clock,  // Q demod clock
	input  wire logic [DIAG_N-1:0] fault_pin,         // Raw diagnostics
	output rsp_type                rsp,               // Read answer
	output logic [1:0]             attenuator_select, // Shield scale
	output logic [1:0]             tia_gain_select,   // TIA feedback
	output logic [2:0]             amp_gain_code,     // Amplifier gain
	output logic [7:0]             i_offset_code,     // I offset DAC
	output logic [7:0]             q_offset_code,     // Q offset DAC
	output logic                   upper_demod_clk,   // Upper path clock
	output logic                   lower_demod_clk,   // Lower path clock
	output logic                   converter_clock,   // ADC clock
	output logic                   adc_reset,         // DSP/ADC reset
	output logic                   conv_done,         // Complete flag
	output logic [13:0]            i_data,            // I result
	output logic [13:0]            q_data,            // Q result
	output logic [10:0]            positive_probe_en, // Plus mux lines
	output logic [10:0]            negative_probe_en, // Minus mux lines
	output logic [DIAG_N-1:0]      fault_report       // Filtered faults
);
	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [10:0] probe_decode(input logic [3:0] c);
		logic [10:0] r;
		r = 11'h000;
		if (c <= PROBE_LAST_LINE) begin
			r = 11'(11'h001 << c);
		end else if (c == PROBE_SHIELD_CODE) begin
			r = 11'h400;
		end
		return r;
	endfunction

	function automatic logic [9:0] offset_adjust(input logic [9:0] s,
			input logic [7:0] code);
		logic [14:0] step;
		step = 15'(OFFSET_STEP * code);
		return ({5'h00, s} > step) ? 10'(({5'h00, s}) - step) : 10'h000;
	endfunction

	// ------------------------------------------------------------------
	// Command decode and settings registers
	// ------------------------------------------------------------------
	conv_state_type state_q;
	logic [7:0]     conv_ctl_q;
	logic [5:0]     blanking_q;
	logic [7:0]     probe_q;
	logic           wr_en;
	logic [7:0]     wr_code;
	logic           ctl_wr;
	logic           data_rd;
	conv_mode_type  wr_mode;

	assign wr_en   = cmd.valid && cmd.code[4] && cmd.code != CMD_DATA_READ;
	assign wr_code = cmd.code & ~WR_FLAG_MASK;
	assign ctl_wr  = wr_en && wr_code == OFS_CONV_CTL;
	assign data_rd = cmd.valid && cmd.code == CMD_DATA_READ;
	assign wr_mode = conv_mode_type'(cmd.wdata[MODE_POS +: 2]);

	// Upper bits of narrow fields are dropped on write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			attenuator_select <= RST_TWO_BIT;
			tia_gain_select   <= RST_TWO_BIT;
			amp_gain_code     <= RST_AMP_GAIN;
			i_offset_code     <= RST_OFFSET;
			q_offset_code     <= RST_OFFSET;
			conv_ctl_q        <= RST_CONV_CTL;
			blanking_q        <= RST_BLANKING;
			probe_q           <= RST_PROBE;
		end else if (wr_en) begin
			unique case (wr_code)
				OFS_SHIELD_ATTEN: attenuator_select <= cmd.wdata[1:0];
				OFS_TIA_GAIN:     tia_gain_select   <= cmd.wdata[1:0];
				OFS_AMP_GAIN:     amp_gain_code     <= cmd.wdata[2:0];
				OFS_I_OFFSET:     i_offset_code     <= cmd.wdata;
				OFS_Q_OFFSET:     q_offset_code     <= cmd.wdata;
				OFS_CONV_CTL:     conv_ctl_q        <= cmd.wdata;
				OFS_BLANKING:     blanking_q        <= cmd.wdata[5:0];
				OFS_PROBE_SEL:    probe_q           <= cmd.wdata;
				default: ;
			endcase
		end
	end

	// demod_route held locally; drives the clock swap below
	logic [1:0] demod_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			demod_q <= RST_TWO_BIT;
		end else if (wr_en && wr_code == OFS_DEMOD_ROUTE) begin
			demod_q <= cmd.wdata[1:0];
		end
	end

	// ------------------------------------------------------------------
	// Read answers
	// ------------------------------------------------------------------
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (cmd.code)
			OFS_SHIELD_ATTEN: rd_val = {30'h0, attenuator_select};
			OFS_TIA_GAIN:     rd_val = {30'h0, tia_gain_select};
			OFS_DEMOD_ROUTE:  rd_val = {30'h0, demod_q};
			OFS_AMP_GAIN:     rd_val = {29'h0, amp_gain_code};
			OFS_I_OFFSET:     rd_val = {24'h0, i_offset_code};
			OFS_Q_OFFSET:     rd_val = {24'h0, q_offset_code};
			OFS_CONV_CTL:     rd_val = {24'h0, conv_ctl_q};
			OFS_BLANKING:     rd_val = {26'h0, blanking_q};
			OFS_PROBE_SEL:    rd_val = {24'h0, probe_q};
			OFS_ADC_STATUS:   rd_val = {31'h0, conv_done};
			CMD_DATA_READ:    rd_val = {2'h0, i_data, 2'h0, q_data};
			default:          rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp <= '0;
		end else begin
			rsp.valid <= cmd.valid && !wr_en;
			rsp.data  <= wr_en ? 32'h0000_0000 : rd_val;
		end
	end

	// ------------------------------------------------------------------
	// Routing and probe outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upper_demod_clk <= 1'b0;
			lower_demod_clk <= 1'b0;
		end else begin
			upper_demod_clk <= (demod_q[0] ? quadrature_clock
				: inphase_clock) ^ demod_q[1];
			lower_demod_clk <= (demod_q[0] ? inphase_clock
				: quadrature_clock) ^ demod_q[1];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			positive_probe_en <= 11'h000;
			negative_probe_en <= 11'h000;
		end else begin
			positive_probe_en <= probe_decode(probe_q[7:4]);
			negative_probe_en <= probe_decode(probe_q[3:0]);
		end
	end

	// ------------------------------------------------------------------
	// Pin synchronisers and blanking
	// ------------------------------------------------------------------
	logic [9:0]        i_meta_q, i_sync_q, q_meta_q, q_sync_q;
	logic [DIAG_N-1:0] f_meta_q, f_sync_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			i_meta_q <= 10'h000;
			i_sync_q <= 10'h000;
			q_meta_q <= 10'h000;
			q_sync_q <= 10'h000;
			f_meta_q <= '0;
			f_sync_q <= '0;
		end else begin
			i_meta_q <= adc_i_pin;
			i_sync_q <= i_meta_q;
			q_meta_q <= adc_q_pin;
			q_sync_q <= q_meta_q;
			f_meta_q <= fault_pin;
			f_sync_q <= f_meta_q;
		end
	end

	for (genvar g = 0; g < DIAG_N; g++) begin : g_blank
		blank_filter u_blank (
			.clk      (clk),
			.nrst     (nrst),
			.fault    (f_sync_q[g]),
			.terminal (blanking_q),
			.report   (fault_report[g])
		);
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	logic [11:0] settle_len;
	logic [4:0]  sample_num;
	logic [11:0] settle_cnt_q;
	logic [4:0]  tick_cnt_q;
	logic [4:0]  samp_cnt_q;
	logic [13:0] acc_i_q, acc_q_q;
	logic        conv_tick;
	logic        sample_tick;
	logic        last_sample;
	logic        restart;

	always_comb begin
		unique case (conv_ctl_q[SETTLE_POS +: 2])
			2'h1:    settle_len = SETTLE_CYC_01;
			2'h2:    settle_len = SETTLE_CYC_10;
			default: settle_len = SETTLE_CYC_00;
		endcase
		unique case (conv_ctl_q[ACCUM_POS +: 2])
			2'h1:    sample_num = SAMPLES_8;
			2'h2:    sample_num = SAMPLES_16;
			default: sample_num = SAMPLES_4;
		endcase
	end

	conv_divider u_div (
		.clk      (clk),
		.nrst     (nrst),
		.run      (state_q == ST_SAMPLE),
		.div_sel  (conv_ctl_q[DIV_POS +: 2]),
		.conv_clk (converter_clock),
		.tick     (conv_tick)
	);

	assign sample_tick = conv_tick
		&& tick_cnt_q == CONV_TICKS_PER_SAMPLE - 5'd1;
	assign last_sample = state_q == ST_SAMPLE && sample_tick
		&& samp_cnt_q == sample_num - 5'd1;
	assign restart = last_sample
		&& conv_ctl_q[MODE_POS +: 2] == MODE_REPEAT;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else if (ctl_wr) begin
			unique case (wr_mode)
				MODE_RESET:  state_q <= ST_IDLE;
				MODE_SINGLE: state_q <= ST_SETTLE;
				MODE_REPEAT: state_q <= ST_SETTLE;
				MODE_STOP:   state_q <= ST_HOLD;
			endcase
		end else begin
			unique case (state_q)
				ST_SETTLE: if (settle_cnt_q == settle_len - 12'd1) begin
					state_q <= ST_SAMPLE;
				end
				ST_SAMPLE: if (last_sample) begin
					state_q <= restart ? ST_SETTLE : ST_HOLD;
				end
				ST_IDLE, ST_HOLD: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			settle_cnt_q <= 12'd0;
		end else if (state_q == ST_SETTLE && !ctl_wr) begin
			settle_cnt_q <= settle_cnt_q + 12'd1;
		end else begin
			settle_cnt_q <= 12'd0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_q <= 5'd0;
			samp_cnt_q <= 5'd0;
			acc_i_q    <= 14'h0000;
			acc_q_q    <= 14'h0000;
		end else if (state_q != ST_SAMPLE || ctl_wr) begin
			tick_cnt_q <= 5'd0;
			samp_cnt_q <= 5'd0;
			acc_i_q    <= 14'h0000;
			acc_q_q    <= 14'h0000;
		end else if (sample_tick) begin
			tick_cnt_q <= 5'd0;
			samp_cnt_q <= samp_cnt_q + 5'd1;
			acc_i_q    <= acc_i_q
				+ 14'(offset_adjust(i_sync_q, i_offset_code));
			acc_q_q    <= acc_q_q
				+ 14'(offset_adjust(q_sync_q, q_offset_code));
		end else if (conv_tick) begin
			tick_cnt_q <= tick_cnt_q + 5'd1;
		end
	end

	// Results and done flag; a finishing cycle wins over a data-read clear, a control write wins over a finishing cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			i_data    <= 14'h0000;
			q_data    <= 14'h0000;
			conv_done <= 1'b0;
		end else if (last_sample && !ctl_wr) begin
			i_data    <= acc_i_q + 14'(offset_adjust(i_sync_q, i_offset_code));
			q_data    <= acc_q_q + 14'(offset_adjust(q_sync_q, q_offset_code));
			conv_done <= 1'b1;
		end else if (data_rd || (ctl_wr && wr_mode != MODE_STOP)) begin
			conv_done <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			adc_reset <= 1'b1;
		end else begin
			adc_reset <= conv_ctl_q[MODE_POS +: 2] == MODE_RESET;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence settle_start_s;
		state_q == ST_IDLE ##1 state_q == ST_SETTLE;
	endsequence

	settle_length_a: assert property (settle_start_s ##0 !ctl_wr [*8]
		|-> state_q == ST_SETTLE) else $error("settle too short");
	done_set_a: assert property (last_sample && !ctl_wr |=> conv_done)
		else $error("done not set");
	done_clear_a: assert property (data_rd && !last_sample |=> !conv_done)
		else $error("done not cleared");
	repeat_restart_a: assert property (restart && !ctl_wr
		|=> state_q == ST_SETTLE) else $error("no restart");
	reset_mode_a: assert property (ctl_wr && wr_mode == MODE_RESET
		|=> state_q == ST_IDLE ##1 adc_reset)
		else $error("reset mode ignored");
	stop_hold_a: assert property (ctl_wr && wr_mode == MODE_STOP
		|=> state_q == ST_HOLD ##1 !converter_clock)
		else $error("stop ignored");
	probe_decode_a: assert property (probe_q[7:4] == PROBE_SHIELD_CODE
		|=> positive_probe_en == 11'h400)
		else $error("shield probe wrong");
	demod_swap_a: assert property (demod_q == 2'h1
		|=> upper_demod_clk == $past(quadrature_clock))
		else $error("demod route wrong");
	offset_write_a: assert property (wr_en && wr_code == OFS_I_OFFSET
		|=> i_offset_code == $past(cmd.wdata))
		else $error("i offset not stored");
	clock_idle_a: assert property (state_q == ST_SETTLE [*2]
		|-> !converter_clock) else $error("clock in settle");
endmodule // capsense_frontend_config_adc_ctl

// ---- bench/host_model.sv ----
// Host model that issues register commands on the command port
`timescale 1ns/1ps
module host_model import capsense_pkg::*; (
	input  wire logic    clk, // Core clock
	output cmd_type      cmd, // Command to the block
	input  wire rsp_type rsp  // Read answer
);
	initial cmd = '0;

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------
	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val);
		@(negedge clk);
		cmd <= '{valid: 1'b1, code: ofs | WR_FLAG_MASK, wdata: val};
		@(negedge clk);
		cmd <= '0;
	endtask

	task automatic read_reg(input logic [7:0] ofs, output logic [31:0] d);
		d = 'x;
		@(negedge clk);
		cmd <= '{valid: 1'b1, code: ofs, wdata: 8'h00};
		@(negedge clk);
		cmd <= '0;
		if (rsp.valid === 1'b1) begin
			d = rsp.data;
		end
	endtask

	// Settings only change while the converter is held in reset
	task automatic conv_start(input logic [7:0] ctl);
		write_reg(OFS_CONV_CTL, 8'h00);
		write_reg(OFS_CONV_CTL, ctl);
	endtask
endmodule // host_model

// ---- bench/testbench.sv ----
// Self-checking testbench for the front-end control block
`timescale 1ns/1ps
module testbench import capsense_pkg::*; ();
	logic              clk;
	logic              nrst;
	cmd_type           cmd;
	rsp_type           rsp;
	logic [9:0]        adc_i_pin;
	logic [9:0]        adc_q_pin;
	logic              inphase_clock;
	logic              quadrature_clock;
	logic [DIAG_N-1:0] fault_pin;
	logic [1:0]        attenuator_select;
	logic [1:0]        tia_gain_select;
	logic [2:0]        amp_gain_code;
	logic [7:0]        i_offset_code;
	logic [7:0]        q_offset_code;
	logic              upper_demod_clk;
	logic              lower_demod_clk;
	logic              converter_clock;
	logic              adc_reset;
	logic              conv_done;
	logic [13:0]       i_data;
	logic [13:0]       q_data;
	logic [10:0]       positive_probe_en;
	logic [10:0]       negative_probe_en;
	logic [DIAG_N-1:0] fault_report;
	logic [31:0]       d;
	logic [10:0]       pe;
	int                num_errors = 0;
	int                num_checks = 0;
	logic [7:0] ofs_tab [9] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
		8'h2a, 8'h2b, 8'h2c};
	logic [7:0] mask_tab [9] = '{8'h03, 8'h03, 8'h03, 8'h07, 8'hff, 8'hff,
		8'hff, 8'h3f, 8'hff};
	logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h3f, 8'hff};
	logic [7:0] vals [2] = '{8'hff, 8'h5b};

	initial clk = 1'b0;
	always #10 clk = ~clk;

	host_model i_host (.clk(clk), .cmd(cmd), .rsp(rsp));

	capsense_frontend_config_adc_ctl i_dut (
		.clk(clk), .nrst(nrst), .cmd(cmd), .adc_i_pin(adc_i_pin),
		.adc_q_pin(adc_q_pin), .inphase_clock(inphase_clock),
		.quadrature_clock(quadrature_clock), .fault_pin(fault_pin),
		.rsp(rsp), .attenuator_select(attenuator_select),
		.tia_gain_select(tia_gain_select), .amp_gain_code(amp_gain_code),
		.i_offset_code(i_offset_code), .q_offset_code(q_offset_code),
		.upper_demod_clk(upper_demod_clk), .lower_demod_clk(lower_demod_clk),
		.converter_clock(converter_clock), .adc_reset(adc_reset),
		.conv_done(conv_done), .i_data(i_data), .q_data(q_data),
		.positive_probe_en(positive_probe_en),
		.negative_probe_en(negative_probe_en), .fault_report(fault_report));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Waits for completion and checks duration and accumulated results
	task automatic wait_done(input int total, input int n, input int p);
		int cnt;
		int hi;
		cnt = 0;
		hi = 0;
		while (conv_done !== 1'b1 && cnt < total + 50) begin
			@(posedge clk);
			#1;
			cnt++;
			hi += int'(converter_clock === 1'b1);
		end
		check(32'(cnt >= total - 4 && cnt <= total + 8), 32'h1);
		check(32'(hi >= n * 11 * p && hi <= n * 11 * p + 2), 32'h1);
		check({18'h0, i_data}, 32'(n * 340));
		check({18'h0, q_data}, 32'(n * 20));
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		final_report();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		adc_i_pin = 10'h1f4;
		adc_q_pin = 10'h064;
		inphase_clock = 1'b1;
		quadrature_clock = 1'b0;
		fault_pin = 4'h0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		check({10'h0, positive_probe_en, negative_probe_en}, 32'h0);
		for (int k = 0; k < 9; k++) begin
			i_host.read_reg(ofs_tab[k], d);
			check(d, {24'h0, rst_tab[k]});
		end
		for (int v = 0; v < 2; v++) begin
			for (int k = 0; k < 9; k++) begin
				if (k == 6)
					i_host.write_reg(OFS_CONV_CTL, 8'h00);
				i_host.write_reg(ofs_tab[k], vals[v]);
				i_host.read_reg(ofs_tab[k], d);
				check(d, {24'h0, vals[v] & mask_tab[k]});
			end
		end
		check({9'h0, attenuator_select, tia_gain_select, amp_gain_code,
			i_offset_code, q_offset_code}, 32'h7b5b5b);
		i_host.read_reg(8'h2d, d);
		check(d, 32'h0);
		for (int j = 0; j < 2; j++) begin
			inphase_clock = (j == 0);
			for (int k = 0; k < 4; k++) begin
				i_host.write_reg(OFS_DEMOD_ROUTE, 8'(k));
				repeat (2) @(negedge clk);
				check({30'h0, upper_demod_clk, lower_demod_clk},
					32'(j ? (k < 2 ? 0 : 3) : ((k == 0 || k == 3) ? 2 : 1)));
			end
		end
		for (int c = 0; c < 16; c++) begin
			i_host.write_reg(OFS_PROBE_SEL, {4'(c), 4'(c)});
			repeat (2) @(negedge clk);
			pe = c < 10 ? 11'(1 << c) : (c == 11 ? 11'h400 : 11'h0);
			check({10'h0, positive_probe_en, negative_probe_en},
				{10'h0, pe, pe});
		end
		i_host.write_reg(OFS_BLANKING, 8'h03);
		fault_pin = 4'h1;
		@(negedge clk);
		check({28'h0, fault_report}, 32'h0);
		repeat (12) @(negedge clk);
		check({28'h0, fault_report}, 32'h1);
		fault_pin = 4'h0;
		repeat (16) @(negedge clk);
		check({28'h0, fault_report}, 32'h0);

		i_host.write_reg(OFS_I_OFFSET, 8'h02);
		i_host.write_reg(OFS_Q_OFFSET, 8'h01);
		i_host.conv_start(8'h19);
		wait_done(1600 + 8 * 22 * 4, 8, 4);
		i_host.read_reg(OFS_ADC_STATUS, d);
		check(d, 32'h1);
		i_host.read_reg(CMD_DATA_READ, d);
		check(d, {2'h0, 14'(8 * 340), 2'h0, 14'(8 * 20)});
		repeat (2) @(negedge clk);
		check({31'h0, conv_done}, 32'h0);
		repeat (2400) @(negedge clk);
		check({31'h0, conv_done}, 32'h0);
		i_host.conv_start(8'h71);
		wait_done(2304 + 4 * 22 * 16, 4, 16);
		i_host.conv_start(8'ha6);
		wait_done(2656 + 16 * 22 * 8, 16, 8);
		i_host.read_reg(CMD_DATA_READ, d);
		check(d, {2'h0, 14'(16 * 340), 2'h0, 14'(16 * 20)});
		wait_done(2656 + 16 * 22 * 8 - 3, 16, 8);
		i_host.read_reg(CMD_DATA_READ, d);
		i_host.write_reg(OFS_CONV_CTL, 8'ha7);
		repeat (5600) @(negedge clk);
		check({31'h0, conv_done}, 32'h0);
		check({31'h0, converter_clock}, 32'h0);
		i_host.write_reg(OFS_CONV_CTL, 8'h00);
		repeat (2) @(negedge clk);
		check({31'h0, adc_reset}, 32'h1);
		final_report();
	end
endmodule // testbench
